// ===== hw/epah_pkg.sv
// constants and state types for the eeprom protect and hold block
// assumes a 1024-byte array and a 40 MHz core clock sampling the spi pins
package epah_pkg;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned CNT_W = 9;
    // spi clock counts seen at the chip select rise
    localparam logic [8:0] CNT_CMD_ONLY = 9'h008;
    localparam logic [8:0] CNT_STATUS_WR = 9'h010;
    localparam logic [8:0] CNT_MEM_WR_MIN = 9'h020;
    localparam logic [8:0] CNT_SAT = 9'h1ff;
    localparam logic [2:0] CNT_BYTE_MASK = 3'h7;
    // field positions in the status byte written by the status write command
    localparam int unsigned SR_LOCK_POS = 7;
    localparam int unsigned SR_PL_HI_POS = 3;
    localparam int unsigned SR_PL_LO_POS = 2;
    // protect level codes
    localparam logic [1:0] PL_NONE = 2'h0;
    localparam logic [1:0] PL_QUARTER = 2'h1;
    localparam logic [1:0] PL_HALF = 2'h2;
    localparam logic [1:0] PL_ALL = 2'h3;
    // reset values
    localparam logic LOCK_RST = 1'b0;
    localparam logic [1:0] PL_RST = 2'h0;

    typedef enum logic [2:0]
    {
        CMD_NONE,
        CMD_WRITE_ENABLE_CMD,
        CMD_WRITE_DISABLE_CMD,
        CMD_STATUS_WRITE_CMD,
        CMD_WRITE
    } epah_cmd_t;

    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_MEM_BUSY,
        ST_SR_BUSY
    } epah_wstate_t;

    typedef struct packed
    {
        logic held;
    } epah_hold_st_t;

    typedef struct packed
    {
        epah_wstate_t st;
        logic cs_q;
        logic sck_q;
        logic [8:0] cnt;
        logic write_enable_latch;
        logic lock;
        logic [1:0] pl;
        logic new_lock;
        logic [1:0] new_pl;
        logic mem_start;
        logic sr_start;
        logic abort;
    } epah_state_t;
endpackage

// ===== hw/epah_hold.sv
// hold-pause tracker for the spi eeprom front end
// assumes sck and hold pins already synchronous to core_clk_i
module epah_hold
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic sck_i,
    input wire logic hold_b_i,
    output logic hold_active_o
);
    import epah_pkg::*;

    epah_hold_st_t state_reg;
    epah_hold_st_t state_next;

    always_comb
    begin
        state_next = state_reg;
        // pin level is only taken while sck is low
        if (!sck_i)
        begin
            state_next.held = ~hold_b_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // sck low: follow the pin at once; sck high: wait for the falling edge
    assign hold_active_o = sck_i ? state_reg.held : ~hold_b_i;

    hold_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !sck_i |-> hold_active_o == !hold_b_i)
        else $error("hold state not following pin while sck low");
    hold_wait_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        sck_i && $past(sck_i) |-> $stable(hold_active_o))
        else $error("hold state changed while sck high");
endmodule

// ===== hw/epah_guard.sv
// write protection, write enable latch and hold gating of a spi eeprom
// assumes a decoder that names the command in the first byte and
// a nonvolatile core that pulses write_done_i when a write finishes
module epah_guard
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic supply_low_i,
    input wire logic cs_b_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic hold_b_i,
    input wire logic wp_b_i,
    input wire logic so_data_i,
    input wire logic so_en_i,
    input wire epah_pkg::epah_cmd_t cmd_i,
    input wire logic [7:0] sr_data_i,
    input wire logic [9:0] addr_i,
    input wire logic write_done_i,
    output logic sck_o,
    output logic si_o,
    output logic so_o,
    output logic so_oe_o,
    output logic hold_active_o,
    output logic hardware_lock_mode_o,
    output logic status_lock_bit_o,
    output logic protect_level_hi_o,
    output logic protect_level_lo_o,
    output logic write_enable_latch_o,
    output logic write_in_progress_flag_o,
    output logic mem_write_start_o,
    output logic status_write_start_o,
    output logic write_abort_o
);
    import epah_pkg::*;

    epah_state_t state_reg;
    epah_state_t state_next;
    logic hold;
    logic cs_rise;
    logic sck_rise;
    logic hw_lock;
    logic addr_prot;
    logic status_ok;
    logic mem_ok;
    logic mem_len_ok;

    epah_hold u_hold
    (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .sck_i(sck_i),
        .hold_b_i(hold_b_i),
        .hold_active_o(hold)
    );

    // level only, so either order of lock bit and pin lands in lock mode
    assign hw_lock = state_reg.lock & ~wp_b_i;

    // region check against the levels in force now, not the pending ones
    always_comb
    begin
        unique case (state_reg.pl)
            PL_NONE: addr_prot = 1'b0;
            PL_QUARTER: addr_prot = &addr_i[ADDR_W-1:ADDR_W-2];
            PL_HALF: addr_prot = addr_i[ADDR_W-1];
            PL_ALL: addr_prot = 1'b1;
        endcase
    end

    assign status_ok = state_reg.write_enable_latch & ~hw_lock;
    assign mem_ok = state_reg.write_enable_latch & ~addr_prot;
    // opcode, two address bytes and whole data bytes only
    assign mem_len_ok = (state_reg.cnt >= CNT_MEM_WR_MIN)
        && ((state_reg.cnt[2:0] & CNT_BYTE_MASK) == 3'h0);

    assign cs_rise = cs_b_i & ~state_reg.cs_q;
    // clock edges during a hold pause are not counted
    assign sck_rise = sck_i & ~state_reg.sck_q & ~hold;

    always_comb
    begin
        state_next = state_reg;
        state_next.cs_q = cs_b_i;
        state_next.sck_q = sck_i;
        state_next.mem_start = 1'b0;
        state_next.sr_start = 1'b0;
        state_next.abort = 1'b0;

        if (cs_b_i)
        begin
            state_next.cnt = '0;
        end
        else if (sck_rise && state_reg.cnt != CNT_SAT)
        begin
            state_next.cnt = state_reg.cnt + 9'h001;
        end

        // commands act only on the chip select rise; a rise while held
        // abandons whatever was being shifted in
        if (cs_rise && !hold && state_reg.st == ST_IDLE)
        begin
            unique case (cmd_i)
                CMD_WRITE_ENABLE_CMD:
                begin
                    if (state_reg.cnt == CNT_CMD_ONLY)
                    begin
                        state_next.write_enable_latch = 1'b1;
                    end
                end
                CMD_WRITE_DISABLE_CMD:
                begin
                    if (state_reg.cnt == CNT_CMD_ONLY)
                    begin
                        state_next.write_enable_latch = 1'b0;
                    end
                end
                CMD_STATUS_WRITE_CMD:
                begin
                    if (state_reg.cnt == CNT_STATUS_WR && status_ok)
                    begin
                        state_next.st = ST_SR_BUSY;
                        state_next.sr_start = 1'b1;
                        state_next.new_lock = sr_data_i[SR_LOCK_POS];
                        state_next.new_pl = {sr_data_i[SR_PL_HI_POS],
                            sr_data_i[SR_PL_LO_POS]};
                    end
                end
                CMD_WRITE:
                begin
                    if (mem_len_ok && mem_ok)
                    begin
                        state_next.st = ST_MEM_BUSY;
                        state_next.mem_start = 1'b1;
                    end
                end
                CMD_NONE:
                begin
                end
            endcase
        end

        if (state_reg.st != ST_IDLE && write_done_i)
        begin
            state_next.write_enable_latch = 1'b0;
            state_next.st = ST_IDLE;
            if (state_reg.st == ST_SR_BUSY)
            begin
                // new status takes effect only here
                state_next.lock = state_reg.new_lock;
                state_next.pl = state_reg.new_pl;
            end
        end

        // low supply cancels starts, latch and busy, but a done in the same cycle still loads the new status
        if (supply_low_i)
        begin
            state_next.write_enable_latch = 1'b0;
            state_next.abort = (state_reg.st != ST_IDLE);
            state_next.st = ST_IDLE;
            state_next.mem_start = 1'b0;
            state_next.sr_start = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_b_i)
        begin
            // power-on leaves the latch clear
            state_reg <= '{st: ST_IDLE, cs_q: 1'b1, sck_q: 1'b0,
                cnt: '0, write_enable_latch: 1'b0, lock: LOCK_RST, pl: PL_RST,
                new_lock: LOCK_RST, new_pl: PL_RST, mem_start: 1'b0,
                sr_start: 1'b0, abort: 1'b0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // gating is combinational so a pause takes effect the same instant
    assign sck_o = sck_i & ~hold;
    assign si_o = si_i & ~hold;
    assign so_o = so_data_i;
    assign so_oe_o = so_en_i & ~cs_b_i & ~hold;
    assign hold_active_o = hold;
    assign hardware_lock_mode_o = hw_lock;
    assign status_lock_bit_o = state_reg.lock;
    assign protect_level_hi_o = state_reg.pl[1];
    assign protect_level_lo_o = state_reg.pl[0];
    assign write_enable_latch_o = state_reg.write_enable_latch;
    assign write_in_progress_flag_o = (state_reg.st != ST_IDLE);
    assign mem_write_start_o = state_reg.mem_start;
    assign status_write_start_o = state_reg.sr_start;
    assign write_abort_o = state_reg.abort;

    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    wel_set_count_a: assert property (
        !$past(write_enable_latch_o) && write_enable_latch_o
        |-> $past(state_reg.cnt) == CNT_CMD_ONLY && $past(cmd_i) == CMD_WRITE_ENABLE_CMD)
        else $error("latch set without exactly eight clocks");
    sr_lock_refuse_a: assert property (
        status_lock_bit_o && !wp_b_i |=> !status_write_start_o)
        else $error("status write started in hardware lock");
    sr_needs_wel_a: assert property (
        !write_enable_latch_o |=> !status_write_start_o && !mem_write_start_o)
        else $error("write started with latch clear");
    mem_prot_a: assert property (
        mem_write_start_o |-> !$past(addr_prot))
        else $error("protected address written");
    supply_clear_a: assert property (
        supply_low_i |=> !write_enable_latch_o && !write_in_progress_flag_o)
        else $error("low supply did not cancel write");
    done_clear_a: assert property (
        write_in_progress_flag_o && write_done_i |=> !write_enable_latch_o)
        else $error("latch not cleared after write");
    hold_so_off_a: assert property (
        hold_active_o |-> !so_oe_o && !sck_o && !si_o)
        else $error("output driven or clock passed during hold");
    cs_high_a: assert property (
        cs_b_i && $past(cs_b_i) |=> !mem_write_start_o && !status_write_start_o)
        else $error("write started while deselected");
    old_status_a: assert property (
        write_in_progress_flag_o && !write_done_i
        |=> $stable(status_lock_bit_o) && $stable(protect_level_lo_o))
        else $error("status changed before write finished");
endmodule

// ===== testbench/epah_host.sv
// host spi controller model: chip select, serial clock, data and hold
// assumes one caller process; pins move 2 ns after the core clock edge
module epah_host
(
    input wire logic core_clk_i,
    output logic cs_b_o,
    output logic sck_o,
    output logic si_o,
    output logic hold_b_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        cs_b_o = 1'b1; // deselected while idle
        sck_o = 1'b0;
        si_o = 1'b0;
        hold_b_o = 1'b1;
    end
    task automatic st();
        @(posedge core_clk_i);
        #2;
    endtask
    // n clocks; hp pauses mid frame, he keeps hold low at the deselect
    task automatic frame(input int n, input bit hp, input bit he);
        cs_b_o = 1'b0;
        st();
        for (int i = 0; i < n; i++)
        begin
            si_o = ~si_o;
            sck_o = 1'b1;
            st();
            hold_b_o = !(hp && i == 2);
            st();
            sck_o = 1'b0;
            st();
            if (hp && i == 2)
            begin
                sck_o = 1'b1; // chip select stays low
                st();
                sck_o = 1'b0;
                st();
                hold_b_o = 1'b1;
                st();
            end
        end
        hold_b_o = !he;
        st();
        cs_b_o = 1'b1;
        st();
        hold_b_o = 1'b1;
    endtask
endmodule

// ===== testbench/epah_guard_test.sv
// self-checking bench for the protect and hold block
// assumes epah_host drives the link pins; the bench drives the rest
module epah_guard_test;
    timeunit 1ns;
    timeprecision 100ps;
    import epah_pkg::*;
    logic clk, rst_b, sup_low, wp_b, so_dat, so_en, done;
    logic cs_b, sck, si, hold_b, sck_g, si_g, so, so_oe, hact, hlm;
    logic lock, plh, pll, write_enable_latch, busy, mws, sws, ab, ms, ss;
    logic h_prev, h_exp, m_wel, m_lock;
    logic [1:0] m_pl;
    logic [3:0] g;
    logic [4:0] st;
    logic [7:0] sr;
    logic [9:0] addr;
    logic [9:0] bnd [4] = '{10'h1ff, 10'h200, 10'h2ff, 10'h300};
    logic [31:0] rnd;
    epah_cmd_t cmd;
    int fail_count = 0;
    int num_checks = 0;
    epah_host host
    (
        .core_clk_i(clk), .cs_b_o(cs_b), .sck_o(sck), .si_o(si),
        .hold_b_o(hold_b)
    );
    epah_guard DUT
    (
        .core_clk_i(clk), .rst_b_i(rst_b), .supply_low_i(sup_low),
        .cs_b_i(cs_b), .sck_i(sck), .si_i(si), .hold_b_i(hold_b),
        .wp_b_i(wp_b), .so_data_i(so_dat), .so_en_i(so_en), .cmd_i(cmd),
        .sr_data_i(sr), .addr_i(addr), .write_done_i(done),
        .sck_o(sck_g), .si_o(si_g), .so_o(so), .so_oe_o(so_oe),
        .hold_active_o(hact), .hardware_lock_mode_o(hlm),
        .status_lock_bit_o(lock), .protect_level_hi_o(plh),
        .protect_level_lo_o(pll), .write_enable_latch_o(write_enable_latch),
        .write_in_progress_flag_o(busy), .mem_write_start_o(mws),
        .status_write_start_o(sws), .write_abort_o(ab)
    );
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    assign h_exp = sck ? h_prev : ~hold_b;
    assign g = {sck, si, so_en & ~cs_b, 1'b1} & {{3{~h_exp}}, 1'b1};
    assign st = {write_enable_latch, busy, lock, plh, pll};
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic bit prot(input logic [1:0] pl, input logic [9:0] a);
        return pl == 2'h3 || (pl == 2'h2 && a >= 10'h200) ||
            (pl == 2'h1 && a >= 10'h300);
    endfunction
    task automatic chk(input logic [4:0] got, input logic [4:0] exp,
        input string what);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #2;
    endtask
    // hold tracking and gating are compared every cycle
    always @(posedge clk)
    begin
        h_prev <= rst_b & h_exp;
        #2;
        so_en = rnd[3];
        so_dat = rnd[9];
    end
    always @(negedge clk)
        if (rst_b)
        begin
            chk({4'h0, hact}, {4'h0, h_exp}, "hold");
            chk({1'b0, sck_g, si_g, so_oe, so}, {g[3:1], so_dat}, "gate");
            chk({4'h0, hlm}, {4'h0, m_lock & ~wp_b}, "mode");
        end
    task automatic run(input epah_cmd_t c, input int n, input bit hp,
        input bit he, input bit cut);
        bit me, se;
        me = 1'b0;
        se = 1'b0;
        cmd = c;
        if (!he && c == CMD_WRITE_ENABLE_CMD && n == 8) m_wel = 1'b1;
        if (!he && c == CMD_WRITE_DISABLE_CMD && n == 8) m_wel = 1'b0;
        if (c == CMD_STATUS_WRITE_CMD)
            se = !he && n == 16 && m_wel && !(m_lock && !wp_b);
        if (c == CMD_WRITE)
            me = !he && n >= 32 && n % 8 == 0 && m_wel && !prot(m_pl, addr);
        host.frame(n, hp, he);
        ms = 1'b0;
        ss = 1'b0;
        repeat (3)
        begin
            ms |= mws;
            ss |= sws;
            step();
        end
        chk({3'h0, ms, ss}, {3'h0, me, se}, "start");
        if (me || se)
        begin
            chk(st, {m_wel, 1'b1, m_lock, m_pl}, "busy");
            sup_low = cut;
            done = !cut;
            step();
            sup_low = 1'b0;
            done = 1'b0;
            m_wel = 1'b0;
            if (se && !cut)
                {m_lock, m_pl} = {sr[7], sr[3:2]};
            chk({4'h0, ab}, {4'h0, cut}, "abort");
            step();
        end
        cmd = CMD_NONE;
        chk(st, {m_wel, 1'b0, m_lock, m_pl}, "state");
    endtask
    initial
    begin
        rst_b = 0; sup_low = 0; wp_b = 1; done = 0; so_en = 0; so_dat = 0;
        cmd = CMD_NONE; sr = 8'h0; addr = 10'h0; rnd = 32'h79bed523;
        m_wel = 0; m_lock = 0; m_pl = 2'h0;
        repeat (8) @(posedge clk);
        #2;
        rst_b = 1'b1;
        chk(st, 5'h0, "reset");
        run(CMD_WRITE_ENABLE_CMD, 7, 0, 0, 0);
        run(CMD_WRITE_ENABLE_CMD, 9, 0, 0, 0);
        run(CMD_WRITE_ENABLE_CMD, 8, 0, 1, 0);
        run(CMD_WRITE_ENABLE_CMD, 8, 1, 0, 0);
        run(CMD_WRITE_DISABLE_CMD, 8, 0, 0, 0);
        run(CMD_WRITE, 32, 0, 0, 0);
        for (int k = 0; k < 16; k++)
        begin
            rnd = nxt(rnd);
            wp_b = rnd[0];
            sr = {rnd[8], rnd[6:4], k[1:0], rnd[2:1]};
            run(CMD_WRITE_ENABLE_CMD, 8, 0, 0, 0);
            run(CMD_STATUS_WRITE_CMD, k == 6 ? 15 : 16, 0, 0, k == 9);
            for (int j = 0; j < 4; j++)
            begin
                rnd = nxt(rnd);
                addr = j[0] ? rnd[9:0] : bnd[rnd[1:0]];
                if (j != 3) run(CMD_WRITE_ENABLE_CMD, 8, 0, 0, 0);
                run(CMD_WRITE, j == 2 ? 40 : 32 + 4 * j[1], 0, 0, 0);
            end
        end
        summarize();
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule
